// >>> rtl/pif_pkg.sv
package pif_pkg;

	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] PIF_ADDR_FLAGS_LOW = 8'h0c;
	localparam logic [7:0] PIF_ADDR_FLAGS_HIGH = 8'h0d;
	localparam logic [7:0] PIF_ADDR_ENABLES_LOW = 8'h8c;
	localparam logic [7:0] PIF_ADDR_ENABLES_HIGH = 8'h8d;
	localparam logic [7:0] PIF_ADDR_CONTROL = 8'h8b;

	// -----------------------------------------------------------------
	// Field positions and masks
	// -----------------------------------------------------------------
	localparam int PIF_BIT_PARALLEL = 7;
	localparam int PIF_BIT_CONVERSION = 6;
	localparam int PIF_BIT_RECEIVE = 5;
	localparam int PIF_BIT_TRANSMIT = 4;
	localparam int PIF_BIT_SYNC_SERIAL = 3;
	localparam int PIF_BIT_CAPCOMP_ONE = 2;
	localparam int PIF_BIT_TIMER_TWO = 1;
	localparam int PIF_BIT_TIMER_ONE = 0;
	localparam int PIF_BIT_COMPARATOR = 6;
	localparam int PIF_BIT_NV_WRITE = 4;
	localparam int PIF_BIT_COLLISION = 3;
	localparam int PIF_BIT_CAPCOMP_TWO = 0;
	localparam int PIF_BIT_GLOBAL_EN = 7;
	localparam int PIF_BIT_PERIPH_EN = 6;
	localparam logic [7:0] PIF_LOW_SW_MASK = 8'hcf;
	localparam logic [7:0] PIF_HIGH_MASK = 8'h59;
	localparam logic [7:0] PIF_CONTROL_MASK = 8'hc0;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] PIF_RESET_VALUE = 8'h00;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		PIF_CC_OFF = 2'b00,
		PIF_CC_CAPTURE = 2'b01,
		PIF_CC_COMPARE = 2'b10,
		PIF_CC_PWM = 2'b11
	} pif_cc_mode_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pif_bus_req_t;

	typedef struct packed {
		logic parallel_access;
		logic conversion_done;
		logic receive_full;
		logic transmit_empty;
		logic sync_serial_done;
		logic capcomp_one_capture;
		logic capcomp_one_match;
		pif_cc_mode_t capcomp_one_mode;
		logic timer_two_match;
		logic timer_one_overflow;
		logic comparator_change;
		logic nv_write_done;
		logic collision;
		logic capcomp_two_capture;
		logic capcomp_two_match;
		pif_cc_mode_t capcomp_two_mode;
	} pif_events_t;

endpackage

// >>> rtl/pif_flags.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ns

module pif_flags (
	input wire logic clock, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire pif_pkg::pif_bus_req_t bus_req, // Register access request.
	output logic [7:0] bus_rdata, // Read data, one cycle after read.
	input wire pif_pkg::pif_events_t events, // Peripheral conditions.
	output logic global_irq_enable, // Global enable state.
	output logic peripheral_irq_enable, // Peripheral enable state.
	output logic irq_request // Combined interrupt request.
);
	import pif_pkg::*;

	// -----------------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------------
	function automatic logic cc_event(input pif_cc_mode_t mode, input logic cap,
		input logic match);
		cc_event = ((mode == PIF_CC_CAPTURE) && cap) || ((mode == PIF_CC_COMPARE) && match);
	endfunction

	function automatic logic [7:0] sticky_next(input logic [7:0] cur, input logic [7:0] set,
		input logic wr, input logic [7:0] wdata, input logic [7:0] mask);
		logic [7:0] base;
		base = wr ? (wdata & mask) : cur;
		sticky_next = (base | set) & mask;
	endfunction

	logic [7:0] flags_low_ff;
	logic [7:0] flags_high_ff;
	logic [7:0] enables_low_ff;
	logic [7:0] enables_high_ff;
	logic [7:0] control_ff;
	logic [7:0] bus_rdata_ff;
	logic [7:0] set_low;
	logic [7:0] set_high;
	logic [7:0] flags_low_view;
	logic [7:0] nxt_flags_low;
	logic [7:0] nxt_flags_high;
	logic wr_flags_low;
	logic wr_flags_high;

	// -----------------------------------------------------------------
	// Event set terms
	// -----------------------------------------------------------------
	// set terms ignore enables
	always_comb begin
		set_low = PIF_RESET_VALUE;
		set_low[PIF_BIT_PARALLEL] = events.parallel_access;
		set_low[PIF_BIT_CONVERSION] = events.conversion_done;
		set_low[PIF_BIT_SYNC_SERIAL] = events.sync_serial_done;
		set_low[PIF_BIT_CAPCOMP_ONE] = cc_event(events.capcomp_one_mode,
			events.capcomp_one_capture, events.capcomp_one_match);
		set_low[PIF_BIT_TIMER_TWO] = events.timer_two_match;
		set_low[PIF_BIT_TIMER_ONE] = events.timer_one_overflow;
		set_high = PIF_RESET_VALUE;
		set_high[PIF_BIT_COMPARATOR] = events.comparator_change;
		set_high[PIF_BIT_NV_WRITE] = events.nv_write_done;
		set_high[PIF_BIT_COLLISION] = events.collision;
		set_high[PIF_BIT_CAPCOMP_TWO] = cc_event(events.capcomp_two_mode,
			events.capcomp_two_capture, events.capcomp_two_match);
	end

	assign wr_flags_low = bus_req.wr && (bus_req.addr == PIF_ADDR_FLAGS_LOW);
	assign wr_flags_high = bus_req.wr && (bus_req.addr == PIF_ADDR_FLAGS_HIGH);

	// -----------------------------------------------------------------
	// Sticky flags
	// -----------------------------------------------------------------
	// set wins over a clearing write
	assign nxt_flags_low = sticky_next(flags_low_ff, set_low, wr_flags_low, bus_req.wdata,
		PIF_LOW_SW_MASK);
	assign nxt_flags_high = sticky_next(flags_high_ff, set_high, wr_flags_high, bus_req.wdata,
		PIF_HIGH_MASK);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_low_ff <= PIF_RESET_VALUE;
		end else begin
			flags_low_ff <= nxt_flags_low;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_high_ff <= PIF_RESET_VALUE;
		end else begin
			flags_high_ff <= nxt_flags_high;
		end
	end

	always_comb begin
		flags_low_view = flags_low_ff;
		flags_low_view[PIF_BIT_RECEIVE] = events.receive_full;
		flags_low_view[PIF_BIT_TRANSMIT] = events.transmit_empty;
	end

	// -----------------------------------------------------------------
	// Enable registers
	// -----------------------------------------------------------------
	// low enables one per source
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enables_low_ff <= PIF_RESET_VALUE;
		end else if (bus_req.wr && (bus_req.addr == PIF_ADDR_ENABLES_LOW)) begin
			enables_low_ff <= bus_req.wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			enables_high_ff <= PIF_RESET_VALUE;
		end else if (bus_req.wr && (bus_req.addr == PIF_ADDR_ENABLES_HIGH)) begin
			enables_high_ff <= bus_req.wdata & PIF_HIGH_MASK;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			control_ff <= PIF_RESET_VALUE;
		end else if (bus_req.wr && (bus_req.addr == PIF_ADDR_CONTROL)) begin
			control_ff <= bus_req.wdata & PIF_CONTROL_MASK;
		end
	end

	assign global_irq_enable = control_ff[PIF_BIT_GLOBAL_EN];
	assign peripheral_irq_enable = control_ff[PIF_BIT_PERIPH_EN];

	// -----------------------------------------------------------------
	// Request
	// -----------------------------------------------------------------
	// Combinational so a new flag reaches the core in the cycle after its event.
	// peripheral enable gate
	assign irq_request = global_irq_enable && peripheral_irq_enable &&
		(|((flags_low_view & enables_low_ff) | (flags_high_ff & enables_high_ff)));

	// -----------------------------------------------------------------
	// Read port
	// -----------------------------------------------------------------
	// Unmapped addresses read zero; reads have no side effects.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus_rdata_ff <= PIF_RESET_VALUE;
		end else if (bus_req.rd) begin
			if (bus_req.addr == PIF_ADDR_FLAGS_LOW) begin
				bus_rdata_ff <= flags_low_view;
			end else if (bus_req.addr == PIF_ADDR_FLAGS_HIGH) begin
				bus_rdata_ff <= flags_high_ff;
			end else if (bus_req.addr == PIF_ADDR_ENABLES_LOW) begin
				bus_rdata_ff <= enables_low_ff;
			end else if (bus_req.addr == PIF_ADDR_ENABLES_HIGH) begin
				bus_rdata_ff <= enables_high_ff;
			end else if (bus_req.addr == PIF_ADDR_CONTROL) begin
				bus_rdata_ff <= control_ff;
			end else begin
				bus_rdata_ff <= PIF_RESET_VALUE;
			end
		end else begin
			bus_rdata_ff <= PIF_RESET_VALUE;
		end
	end

	assign bus_rdata = bus_rdata_ff;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	sequence s_clear_write_low;
		wr_flags_low && !bus_req.wdata[PIF_BIT_TIMER_ONE];
	endsequence

	chk_overflow_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
		events.timer_one_overflow |=> flags_low_ff[PIF_BIT_TIMER_ONE])
		else $error("timer one overflow did not set its flag");

	chk_set_beats_clear: assert property (@(posedge clock) disable iff (!rst_n)
		s_clear_write_low ##0 events.timer_one_overflow |=> flags_low_ff[PIF_BIT_TIMER_ONE])
		else $error("clearing write lost a timer one overflow");

	chk_flag_stays_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		flags_high_ff[PIF_BIT_COMPARATOR] && !wr_flags_high
		|=> flags_high_ff[PIF_BIT_COMPARATOR])
		else $error("comparator flag cleared without a write");

	chk_flag_clear_write: assert property (@(posedge clock) disable iff (!rst_n)
		wr_flags_high && !bus_req.wdata[PIF_BIT_NV_WRITE] && !events.nv_write_done
		|=> !flags_high_ff[PIF_BIT_NV_WRITE])
		else $error("write of zero did not clear nonvolatile flag");

	chk_high_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
		((flags_high_ff | enables_high_ff) & ~PIF_HIGH_MASK) == PIF_RESET_VALUE)
		else $error("unimplemented high bit became set");

	chk_receive_mirror: assert property (@(posedge clock) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == PIF_ADDR_FLAGS_LOW
		|=> bus_rdata[PIF_BIT_RECEIVE] == $past(events.receive_full))
		else $error("receive flag does not follow buffer state");

	chk_global_gate: assert property (@(posedge clock) disable iff (!rst_n)
		!global_irq_enable |-> !irq_request)
		else $error("request raised with global enable low");

	chk_periph_gate: assert property (@(posedge clock) disable iff (!rst_n)
		!peripheral_irq_enable |-> !irq_request)
		else $error("request raised with peripheral enable low");

	chk_request_raised: assert property (@(posedge clock) disable iff (!rst_n)
		global_irq_enable && peripheral_irq_enable && enables_low_ff[PIF_BIT_TIMER_TWO]
		&& events.timer_two_match |=> ##0 (irq_request || !$stable(control_ff)
		|| !$stable(enables_low_ff)))
		else $error("enabled timer two match raised no request");

	chk_pwm_no_set: assert property (@(posedge clock) disable iff (!rst_n)
		events.capcomp_one_mode == PIF_CC_PWM && !flags_low_ff[PIF_BIT_CAPCOMP_ONE]
		&& !wr_flags_low |=> !flags_low_ff[PIF_BIT_CAPCOMP_ONE])
		else $error("capcomp one flag set in pwm mode");

	// -----------------------------------------------------------------
	// Event checks
	// -----------------------------------------------------------------
	// A clearing write in the same cycle cannot hide these sets, because the set wins.
	chk_parallel_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
		events.parallel_access |=> flags_low_ff[PIF_BIT_PARALLEL])
		else $error("parallel port access did not set its flag");

	chk_conversion_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
		events.conversion_done |=> flags_low_ff[PIF_BIT_CONVERSION])
		else $error("finished conversion did not set its flag");

	chk_conversion_stays_clear: assert property (@(posedge clock) disable iff (!rst_n)
		!flags_low_ff[PIF_BIT_CONVERSION] && !events.conversion_done && !wr_flags_low
		|=> !flags_low_ff[PIF_BIT_CONVERSION])
		else $error("conversion flag set with no finished conversion");

	chk_sync_serial_sets: assert property (@(posedge clock) disable iff (!rst_n)
		events.sync_serial_done |=> flags_low_ff[PIF_BIT_SYNC_SERIAL])
		else $error("sync serial completion did not set its flag");

	sequence s_capcomp_one_hit;
		(events.capcomp_one_mode == PIF_CC_CAPTURE && events.capcomp_one_capture)
		|| (events.capcomp_one_mode == PIF_CC_COMPARE && events.capcomp_one_match);
	endsequence

	chk_capcomp_one_sets: assert property (@(posedge clock) disable iff (!rst_n)
		s_capcomp_one_hit |=> flags_low_ff[PIF_BIT_CAPCOMP_ONE])
		else $error("capcomp one event did not set its flag");

	chk_timer_two_sets: assert property (@(posedge clock) disable iff (!rst_n)
		events.timer_two_match |=> flags_low_ff[PIF_BIT_TIMER_TWO])
		else $error("timer two match did not set its flag");

	chk_comparator_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
		events.comparator_change |=> flags_high_ff[PIF_BIT_COMPARATOR])
		else $error("comparator change did not set its flag");

	chk_nv_write_sets: assert property (@(posedge clock) disable iff (!rst_n)
		events.nv_write_done |=> flags_high_ff[PIF_BIT_NV_WRITE])
		else $error("nonvolatile write finish did not set its flag");

	chk_nv_stays_clear: assert property (@(posedge clock) disable iff (!rst_n)
		!flags_high_ff[PIF_BIT_NV_WRITE] && !events.nv_write_done && !wr_flags_high
		|=> !flags_high_ff[PIF_BIT_NV_WRITE])
		else $error("nonvolatile flag set with no finished write");

	chk_collision_sets_flag: assert property (@(posedge clock) disable iff (!rst_n)
		events.collision |=> flags_high_ff[PIF_BIT_COLLISION])
		else $error("bus collision did not set its flag");

	sequence s_capcomp_two_hit;
		(events.capcomp_two_mode == PIF_CC_CAPTURE && events.capcomp_two_capture)
		|| (events.capcomp_two_mode == PIF_CC_COMPARE && events.capcomp_two_match);
	endsequence

	chk_capcomp_two_sets: assert property (@(posedge clock) disable iff (!rst_n)
		s_capcomp_two_hit |=> flags_high_ff[PIF_BIT_CAPCOMP_TWO])
		else $error("capcomp two event did not set its flag");

	chk_pwm_two_quiet: assert property (@(posedge clock) disable iff (!rst_n)
		events.capcomp_two_mode == PIF_CC_PWM && !flags_high_ff[PIF_BIT_CAPCOMP_TWO]
		&& !wr_flags_high |=> !flags_high_ff[PIF_BIT_CAPCOMP_TWO])
		else $error("capcomp two flag set in pwm mode");

	// -----------------------------------------------------------------
	// Register checks
	// -----------------------------------------------------------------
	// Receive and transmit bits are live views, so their stored copies must stay zero.
	chk_low_readonly_zero: assert property (@(posedge clock) disable iff (!rst_n)
		(flags_low_ff & ~PIF_LOW_SW_MASK) == PIF_RESET_VALUE)
		else $error("read-only low flag bit was stored");

	chk_transmit_mirror: assert property (@(posedge clock) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == PIF_ADDR_FLAGS_LOW
		|=> bus_rdata[PIF_BIT_TRANSMIT] == $past(events.transmit_empty))
		else $error("transmit flag does not follow buffer state");

	chk_low_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n)
		flags_low_ff[PIF_BIT_TIMER_ONE] && !wr_flags_low
		|=> flags_low_ff[PIF_BIT_TIMER_ONE])
		else $error("timer one flag cleared without a write");

	chk_low_clear_write: assert property (@(posedge clock) disable iff (!rst_n)
		wr_flags_low && !bus_req.wdata[PIF_BIT_SYNC_SERIAL] && !events.sync_serial_done
		|=> !flags_low_ff[PIF_BIT_SYNC_SERIAL])
		else $error("write of zero did not clear sync serial flag");

	sequence s_write_enables_high;
		bus_req.wr && bus_req.addr == PIF_ADDR_ENABLES_HIGH;
	endsequence

	chk_high_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_enables_high |=> enables_high_ff == ($past(bus_req.wdata) & PIF_HIGH_MASK))
		else $error("high enable write did not land on its bits");

	sequence s_write_enables_low;
		bus_req.wr && bus_req.addr == PIF_ADDR_ENABLES_LOW;
	endsequence

	chk_low_enable_write: assert property (@(posedge clock) disable iff (!rst_n)
		s_write_enables_low |=> enables_low_ff == $past(bus_req.wdata))
		else $error("low enable write did not land");

	sequence s_read_flags_high;
		bus_req.rd && bus_req.addr == PIF_ADDR_FLAGS_HIGH;
	endsequence

	chk_high_flag_read: assert property (@(posedge clock) disable iff (!rst_n)
		s_read_flags_high |=> bus_rdata == $past(flags_high_ff))
		else $error("high flag read returned wrong data");

	sequence s_global_off_write;
		bus_req.wr && bus_req.addr == PIF_ADDR_CONTROL && !bus_req.wdata[PIF_BIT_GLOBAL_EN];
	endsequence

	chk_global_off_write: assert property (@(posedge clock) disable iff (!rst_n)
		s_global_off_write |=> !irq_request)
		else $error("request stayed up after global enable was cleared");

	chk_request_from_high: assert property (@(posedge clock) disable iff (!rst_n)
		global_irq_enable && peripheral_irq_enable && enables_high_ff[PIF_BIT_COLLISION]
		&& events.collision |=> irq_request || !$stable(control_ff) || !$stable(enables_high_ff))
		else $error("enabled collision raised no request");

endmodule

// >>> test/pif_periph_model.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------
// Peripheral side: turns bench requests into condition pulses and buffer levels
// -----------------------------------------------------------------
module pif_periph_model (
	input wire logic [7:0] fire_low, // Pulse per low flag position.
	input wire logic [7:0] fire_high, // Pulse per high flag position.
	input wire logic cc_match, // Capcomp events are matches, else captures.
	input wire pif_pkg::pif_cc_mode_t cc_mode, // Mode of both capcomp units.
	input wire logic rx_full, // Receive buffer holds data.
	input wire logic tx_empty, // Transmit buffer is empty.
	output pif_pkg::pif_events_t events // Conditions seen by the flags.
);
	import pif_pkg::*;

	// buffer levels held
	// Buffer states are levels that the peripheral holds, never pulses.
	always_comb begin
		events = '0;
		events.parallel_access = fire_low[7];
		events.conversion_done = fire_low[6];
		events.receive_full = rx_full;
		events.transmit_empty = tx_empty;
		events.sync_serial_done = fire_low[3];
		events.capcomp_one_capture = fire_low[2] & ~cc_match;
		events.capcomp_one_match = fire_low[2] & cc_match;
		events.capcomp_one_mode = cc_mode;
		events.timer_two_match = fire_low[1];
		events.timer_one_overflow = fire_low[0];
		events.comparator_change = fire_high[6];
		events.nv_write_done = fire_high[4];
		events.collision = fire_high[3];
		events.capcomp_two_capture = fire_high[0] & ~cc_match;
		events.capcomp_two_match = fire_high[0] & cc_match;
		events.capcomp_two_mode = cc_mode;
	end
endmodule

// >>> test/pif_flags_tb.sv
`timescale 1ns/1ns
module pif_flags_tb;
	import pif_pkg::*;

	logic clock = 1'b0;
	logic rst_n = 1'b0;
	pif_bus_req_t req = '0;
	logic [7:0] rdata;
	logic [7:0] fl = 8'h00;
	logic [7:0] fh = 8'h00;
	logic ccm = 1'b0;
	logic rx = 1'b0;
	logic tx = 1'b0;
	logic g_en;
	logic p_en;
	logic irq;
	pif_cc_mode_t mode = PIF_CC_CAPTURE;
	pif_events_t ev;
	int n_errors = 0;
	int compares = 0;
	int lb[6] = '{7, 6, 3, 2, 1, 0};
	int hb[4] = '{6, 4, 3, 0};

	pif_periph_model model (.fire_low(fl), .fire_high(fh), .cc_match(ccm), .cc_mode(mode),
		.rx_full(rx), .tx_empty(tx), .events(ev));
	pif_flags DUT (.clock(clock), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
		.events(ev), .global_irq_enable(g_en), .peripheral_irq_enable(p_en),
		.irq_request(irq));

	initial begin
		forever #10 clock = ~clock;
	end

	// -----------------------------------------------------------------
	// Bus and check tasks
	// -----------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Every task ends one edge after its strobe drops, so strobes never collide.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock);
		req.wr <= 1'b0;
		@(posedge clock);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1 chk(nm, rdata, exp);
		@(posedge clock);
	endtask

	task automatic fire(input logic [7:0] l, input logic [7:0] h);
		fl <= l;
		fh <= h;
		@(posedge clock);
		fl <= 8'h00;
		fh <= 8'h00;
		@(posedge clock);
	endtask

	task automatic irqchk(input logic e);
		#1 chk("irq_request", {7'h00, irq}, {7'h00, e});
		@(posedge clock);
	endtask

	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Tests
	// -----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		rd(PIF_ADDR_FLAGS_LOW, PIF_RESET_VALUE, "flags_low");
		rd(PIF_ADDR_FLAGS_HIGH, PIF_RESET_VALUE, "flags_high");
		rd(PIF_ADDR_ENABLES_LOW, PIF_RESET_VALUE, "enables_low");
		rd(PIF_ADDR_ENABLES_HIGH, PIF_RESET_VALUE, "enables_high");
		rd(PIF_ADDR_CONTROL, PIF_RESET_VALUE, "control");
		rd(8'h55, 8'h00, "unmapped");
		$display("test reset done");
		foreach (lb[i]) begin
			fire(8'h01 << lb[i], 8'h00);
			rd(PIF_ADDR_FLAGS_LOW, 8'h01 << lb[i], "low flag");
			irqchk(1'b0);
			wr(PIF_ADDR_FLAGS_LOW, 8'h00);
			rd(PIF_ADDR_FLAGS_LOW, 8'h00, "low cleared");
		end
		foreach (hb[i]) begin
			fire(8'h00, 8'h01 << hb[i]);
			rd(PIF_ADDR_FLAGS_HIGH, 8'h01 << hb[i], "high flag");
			wr(PIF_ADDR_FLAGS_HIGH, 8'h00);
			rd(PIF_ADDR_FLAGS_HIGH, 8'h00, "high cleared");
		end
		$display("test event flags done");
		rx <= 1'b1;
		wr(PIF_ADDR_FLAGS_LOW, 8'hff);
		rd(PIF_ADDR_FLAGS_LOW, 8'hef, "rx full tx full");
		rx <= 1'b0;
		tx <= 1'b1;
		wr(PIF_ADDR_FLAGS_LOW, 8'h00);
		rd(PIF_ADDR_FLAGS_LOW, 8'h10, "rx empty tx empty");
		tx <= 1'b0;
		wr(PIF_ADDR_FLAGS_HIGH, 8'hff);
		rd(PIF_ADDR_FLAGS_HIGH, PIF_HIGH_MASK, "high layout");
		wr(PIF_ADDR_ENABLES_HIGH, 8'hff);
		rd(PIF_ADDR_ENABLES_HIGH, PIF_HIGH_MASK, "high enables");
		wr(PIF_ADDR_ENABLES_LOW, 8'ha5);
		rd(PIF_ADDR_ENABLES_LOW, 8'ha5, "low enables");
		wr(PIF_ADDR_FLAGS_HIGH, 8'h00);
		$display("test layout done");
		mode <= PIF_CC_OFF;
		fire(8'h04, 8'h01);
		rd(PIF_ADDR_FLAGS_LOW, 8'h00, "off capcomp one");
		rd(PIF_ADDR_FLAGS_HIGH, 8'h00, "off capcomp two");
		mode <= PIF_CC_PWM;
		fire(8'h04, 8'h01);
		rd(PIF_ADDR_FLAGS_LOW, 8'h00, "pwm capcomp one");
		rd(PIF_ADDR_FLAGS_HIGH, 8'h00, "pwm capcomp two");
		mode <= PIF_CC_COMPARE;
		ccm <= 1'b1;
		fire(8'h04, 8'h01);
		rd(PIF_ADDR_FLAGS_LOW, 8'h04, "match capcomp one");
		rd(PIF_ADDR_FLAGS_HIGH, 8'h01, "match capcomp two");
		// Stale flags are cleared before the global and peripheral enables go up.
		wr(PIF_ADDR_FLAGS_LOW, 8'h00);
		wr(PIF_ADDR_FLAGS_HIGH, 8'h00);
		$display("test capcomp modes done");
		wr(PIF_ADDR_ENABLES_LOW, 8'h01);
		fire(8'h01, 8'h00);
		wr(PIF_ADDR_CONTROL, 8'h80);
		irqchk(1'b0);
		wr(PIF_ADDR_CONTROL, 8'h40);
		irqchk(1'b0);
		wr(PIF_ADDR_CONTROL, 8'hff);
		irqchk(1'b1);
		chk("global enable", {7'h00, g_en}, 8'h01);
		chk("periph enable", {7'h00, p_en}, 8'h01);
		rd(PIF_ADDR_CONTROL, PIF_CONTROL_MASK, "control");
		wr(PIF_ADDR_FLAGS_LOW, 8'h00);
		irqchk(1'b0);
		fire(8'h00, 8'h08);
		irqchk(1'b1);
		wr(PIF_ADDR_FLAGS_HIGH, 8'h00);
		rx <= 1'b1;
		wr(PIF_ADDR_ENABLES_LOW, 8'h20);
		irqchk(1'b1);
		rx <= 1'b0;
		wr(PIF_ADDR_ENABLES_LOW, 8'h02);
		irqchk(1'b0);
		fire(8'h02, 8'h00);
		irqchk(1'b1);
		wr(PIF_ADDR_FLAGS_LOW, 8'h00);
		$display("test request gating done");
		req.addr <= PIF_ADDR_FLAGS_LOW;
		req.wdata <= 8'h00;
		req.wr <= 1'b1;
		fl <= 8'h01;
		@(posedge clock);
		req.wr <= 1'b0;
		fl <= 8'h00;
		@(posedge clock);
		rd(PIF_ADDR_FLAGS_LOW, 8'h01, "set beats clear");
		$display("test collision of set and clear done");
		test_done;
	end

	initial begin
		repeat (3000) @(posedge clock);
		n_errors++;
		test_done;
	end
endmodule
